// *** dual_timer_counter_core.sv ***
// Two 16-bit timer/counters with an AHB-Lite register slave
`timescale 1ns/1ps
`include "timer_consts.svh"
module dual_timer_counter_core
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // External pins
   input wire logic count_pin_a,
   input wire logic count_pin_b,
   input wire logic external_interrupt_pin_a,
   input wire logic external_interrupt_pin_b,
   // Interrupt vectoring acknowledge from the processor
   input wire logic vector_ack_a,
   input wire logic vector_ack_b,
   // Interrupt requests
   output logic irq_a,
   output logic irq_b
);
   logic [7:0] control_register;
   logic [7:0] mode_register;
   logic [2:0] clock_config_register;
   logic [11:0] wr_addr;
   bus_phase_e phase;
   wire [7:0] low_a;
   wire [7:0] high_a;
   wire [7:0] low_b;
   wire [7:0] high_b;
   wire ovf_a;
   wire ovf_b;
   wire tick_a;
   wire tick_b;
   wire take;
   wire wr_now;
   wire [31:0] next_rdata;
   wire clear_a;
   wire clear_b;
   wire [7:0] next_control;

   // Address phase accepted
   assign take = hsel && hready && htrans[1];
   assign wr_now = (phase == BUS_WRITE);

   // Per-timer rate generators
   timer_rate_gen gen_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .clock_select(clock_config_register[`CLK_A_SEL]),
      .double_speed_mode(clock_config_register[`CLK_DOUBLE]),
      .per_cycle_tick(tick_a)
   );
   timer_rate_gen gen_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .clock_select(clock_config_register[`CLK_B_SEL]),
      .double_speed_mode(clock_config_register[`CLK_DOUBLE]),
      .per_cycle_tick(tick_b)
   );

   // Timer A on low mode nibble and control bits 4,5
   timer_channel chan_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .per_cycle_tick(tick_a),
      .count_pin(count_pin_a),
      .external_interrupt_pin(external_interrupt_pin_a),
      .run_control_bit(control_register[`CTL_A_RUN]),
      .gate_enable_bit(mode_register[`MODE_A_LSB + 3]),
      .source_select(mode_register[`MODE_A_LSB + 2]),
      .mode_select(mode_register[`MODE_A_LSB + 1 : `MODE_A_LSB]),
      .load_low(wr_now && wr_addr == `OFF_A_LOW),
      .load_high(wr_now && wr_addr == `OFF_A_HIGH),
      .load_data(hwdata[7:0]),
      .count_low_byte(low_a),
      .count_high_byte(high_a),
      .overflow_pulse(ovf_a)
   );
   // Timer B on high mode nibble and control bits 6,7
   timer_channel chan_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .per_cycle_tick(tick_b),
      .count_pin(count_pin_b),
      .external_interrupt_pin(external_interrupt_pin_b),
      .run_control_bit(control_register[`CTL_B_RUN]),
      .gate_enable_bit(mode_register[`MODE_B_LSB + 3]),
      .source_select(mode_register[`MODE_B_LSB + 2]),
      .mode_select(mode_register[`MODE_B_LSB + 1 : `MODE_B_LSB]),
      .load_low(wr_now && wr_addr == `OFF_B_LOW),
      .load_high(wr_now && wr_addr == `OFF_B_HIGH),
      .load_data(hwdata[7:0]),
      .count_low_byte(low_b),
      .count_high_byte(high_b),
      .overflow_pulse(ovf_b)
   );

   // Flag clears from vectoring or the acknowledge register; set wins
   assign clear_a = vector_ack_a || (wr_now && wr_addr == `OFF_INTACK && hwdata[0]);
   assign clear_b = vector_ack_b || (wr_now && wr_addr == `OFF_INTACK && hwdata[1]);

   // Control register update: software write, then clears, then overflow sets
   function automatic logic [7:0] control_update(input logic [7:0] cur);
      logic [7:0] v;
      v = cur;
      if (wr_now && wr_addr == `OFF_CONTROL)
         v = hwdata[7:0];
      if (clear_a)
         v[`CTL_A_FLAG] = 1'b0;
      if (clear_b)
         v[`CTL_B_FLAG] = 1'b0;
      if (ovf_a)
         v[`CTL_A_FLAG] = 1'b1;
      if (ovf_b)
         v[`CTL_B_FLAG] = 1'b1;
      return v;
   endfunction
   assign next_control = control_update(control_register);

   // Read multiplexer
   assign next_rdata =
      (haddr == `OFF_CONTROL) ? {24'h00_0000, control_register} :
      (haddr == `OFF_MODE) ? {24'h00_0000, mode_register} :
      (haddr == `OFF_CLKCFG) ? {29'h0000_0000, clock_config_register} :
      (haddr == `OFF_A_LOW) ? {24'h00_0000, low_a} :
      (haddr == `OFF_A_HIGH) ? {24'h00_0000, high_a} :
      (haddr == `OFF_B_LOW) ? {24'h00_0000, low_b} :
      (haddr == `OFF_B_HIGH) ? {24'h00_0000, high_b} :
      (haddr == `OFF_STATUS) ? {30'h0000_0000, control_register[`CTL_B_FLAG],
                                control_register[`CTL_A_FLAG]} :
      32'h0000_0000;

   // Bus phase tracking; zero-wait slave
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         phase <= BUS_IDLE;
         wr_addr <= 12'h000;
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         if (take && hwrite)
            phase <= BUS_WRITE;
         else if (take)
            phase <= BUS_READ;
         else if (hready)
            phase <= BUS_IDLE;
         if (take)
            wr_addr <= haddr;
         if (take && !hwrite)
            hrdata <= next_rdata;
      end
   end

   // Static bus answers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Software-visible configuration and flags
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         control_register <= `RST_BYTE;
         mode_register <= `RST_BYTE;
         clock_config_register <= 3'h0;
         irq_a <= 1'b0;
         irq_b <= 1'b0;
      end
      else
      begin
         control_register <= next_control;
         if (wr_now && wr_addr == `OFF_MODE)
            mode_register <= hwdata[7:0];
         if (wr_now && wr_addr == `OFF_CLKCFG)
            clock_config_register <= hwdata[2:0];
         irq_a <= next_control[`CTL_A_FLAG];
         irq_b <= next_control[`CTL_B_FLAG];
      end
   end
endmodule // dual_timer_counter_core

// *** timer_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define OFF_CONTROL 12'h000
`define OFF_MODE 12'h004
`define OFF_CLKCFG 12'h008
`define OFF_A_LOW 12'h00C
`define OFF_A_HIGH 12'h010
`define OFF_B_LOW 12'h014
`define OFF_B_HIGH 12'h018
`define OFF_INTACK 12'h01C
`define OFF_STATUS 12'h020
`define CTL_A_RUN 4
`define CTL_A_FLAG 5
`define CTL_B_RUN 6
`define CTL_B_FLAG 7
`define CLK_A_SEL 0
`define CLK_B_SEL 1
`define CLK_DOUBLE 2
`define MODE_A_LSB 0
`define MODE_B_LSB 4
`define RST_BYTE 8'h00
`define PER_CLOCKS 6
`define PRESCALE_MASK 8'h1F
`endif

// *** timer_pkg.sv ***
// Types shared by the timer block
package timer_pkg;
   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } timer_mode_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ = 2'b10
   } bus_phase_e;
endpackage

// *** timer_rate_gen.sv ***
// Divider that yields the timer clock enable and the peripheral-cycle enable
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_rate_gen
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Selection
   input wire logic clock_select,
   input wire logic double_speed_mode,
   // Enables
   output logic per_cycle_tick
);
   logic half;
   logic [2:0] per_count;
   wire timer_clk_en;
   wire last_period;

   // Undivided oscillator only when double speed and select clear
   assign timer_clk_en = (double_speed_mode && !clock_select) ? 1'b1 : half;
   assign last_period = (per_count == 3'(`PER_CLOCKS - 1));

   // Divide by 2 and then by 6 timer clock periods
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         half <= 1'b0;
         per_count <= 3'h0;
         per_cycle_tick <= 1'b0;
      end
      else
      begin
         half <= ~half;
         per_cycle_tick <= timer_clk_en && last_period;
         if (timer_clk_en)
            per_count <= last_period ? 3'h0 : per_count + 3'h1;
      end
   end
endmodule // timer_rate_gen

// *** timer_channel.sv ***
// One timer/counter: source select, gating, edge sampling and count datapath
`timescale 1ns/1ps
`include "timer_consts.svh"
module timer_channel
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Enables and pins
   input wire logic per_cycle_tick,
   input wire logic count_pin,
   input wire logic external_interrupt_pin,
   // Configuration
   input wire logic run_control_bit,
   input wire logic gate_enable_bit,
   input wire logic source_select,
   input wire logic [1:0] mode_select,
   // Software preset of count bytes
   input wire logic load_low,
   input wire logic load_high,
   input wire logic [7:0] load_data,
   // Count state
   output logic [7:0] count_low_byte,
   output logic [7:0] count_high_byte,
   output logic overflow_pulse
);
   logic pin_sample;
   wire run_ok;
   wire falling;
   wire step;
   wire low_wrap;
   wire pre_wrap;
   wire high_wrap;
   wire is_13;
   wire is_16;
   wire [7:0] next_low;
   wire [7:0] next_high;

   // Gating, source and mode decode
   assign run_ok = run_control_bit && (!gate_enable_bit || external_interrupt_pin);
   assign falling = pin_sample && !count_pin;
   assign step = per_cycle_tick && run_ok && (source_select ? falling : 1'b1);
   assign is_13 = (mode_select == MODE_13BIT);
   assign is_16 = (mode_select == MODE_16BIT);
   assign low_wrap = (count_low_byte == 8'hFF);
   assign pre_wrap = (count_low_byte[4:0] == 5'h1F);
   assign high_wrap = (count_high_byte == 8'hFF);
   // 13-bit: prescaler in low five bits, upper three held; 16-bit: full cascade
   assign next_low = is_13 ? {count_low_byte[7:5], count_low_byte[4:0] + 5'h01}
                           : count_low_byte + 8'h01;
   assign next_high = count_high_byte + 8'h01;

   // Edge sample once per peripheral cycle
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pin_sample <= 1'b0;
      else if (per_cycle_tick)
         pin_sample <= count_pin;
   end

   // Count bytes advance from their current contents
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         count_low_byte <= `RST_BYTE;
         count_high_byte <= `RST_BYTE;
         overflow_pulse <= 1'b0;
      end
      else
      begin
         overflow_pulse <= 1'b0;
         if (load_low)
            count_low_byte <= load_data;
         else if (step && (is_13 || is_16))
            count_low_byte <= next_low;
         if (load_high)
            count_high_byte <= load_data;
         else if (step && ((is_13 && pre_wrap) || (is_16 && low_wrap)))
         begin
            count_high_byte <= next_high;
            overflow_pulse <= high_wrap;
         end
      end
   end
endmodule // timer_channel

// *** count_source.sv ***
// Model of the external event source that drives one count pin
`timescale 1ns/1ps
module count_source #(
   parameter int HALF = 24
) (
   // Clock
   input wire logic mclk,
   // Control and pin
   input wire logic en,
   output logic count_pin
);
   int cnt = 0;
   logic lvl = 1'b1;
   assign count_pin = lvl;
   // Each level is held HALF cycles, longer than one peripheral cycle
   always @(posedge mclk)
   begin
      if (!en)
         cnt <= 0;
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         lvl <= !lvl;
      end
      else
         cnt <= cnt + 1;
   end
endmodule // count_source

// *** dual_timer_counter_core_asserts.sv ***
// Concurrent checks on the ports of the timer block
`timescale 1ns/1ps
module dual_timer_counter_core_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Flags
   input wire logic vector_ack_a,
   input wire logic vector_ack_b,
   input wire logic irq_a,
   input wire logic irq_b
);
   // Write transfer taken at this edge
   wire wr = hsel && hready && htrans[1] && hwrite;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Bus: always OKAY, no wait states, byte-wide data held between reads
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("hresp not okay");
   property p_ready; $past(rst_n) |-> hreadyout; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_upper; hrdata[31:8] == 24'h00_0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   // Quiet start after reset
   property p_quiet; $rose(rst_n) |-> !irq_a && !irq_b && !hreadyout && hrdata == 32'h0000_0000;
   endproperty
   a_quiet: assert property (p_quiet) else $error("outputs active after reset");
   // Flags clear on vectoring and otherwise stay set, except right after a write transfer
   property p_clear_a; vector_ack_a |=> !irq_a; endproperty
   a_clear_a: assert property (p_clear_a) else $error("flag a not cleared");
   property p_clear_b; vector_ack_b |=> !irq_b; endproperty
   a_clear_b: assert property (p_clear_b) else $error("flag b not cleared");
   property p_sticky_a; irq_a && !vector_ack_a && !$past(wr) |=> irq_a; endproperty
   a_sticky_a: assert property (p_sticky_a) else $error("flag a dropped");
   property p_sticky_b; irq_b && !vector_ack_b && !$past(wr) |=> irq_b; endproperty
   a_sticky_b: assert property (p_sticky_b) else $error("flag b dropped");
endmodule // dual_timer_counter_core_asserts

bind dual_timer_counter_core dual_timer_counter_core_asserts dual_timer_counter_core_asserts_inst (
   .mclk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .vector_ack_a, .vector_ack_b, .irq_a, .irq_b);

// *** dual_timer_counter_core_tb_top.sv ***
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`include "timer_consts.svh"
module dual_timer_counter_core_tb_top;
   logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic en_a = 1'b0, en_b = 1'b0, ext_a = 1'b0, ext_b = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'b00;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq_a, irq_b, pin_a, pin_b;
   logic [7:0] q;
   logic [31:0] seed = 32'hb5de_b3b2;
   int mismatches = 0;
   int checks = 0;
   // Clock
   initial
   begin
      forever #12.5 mclk = ~mclk;
   end
   dual_timer_counter_core dual_timer_counter_core_inst (
      .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .count_pin_a(pin_a), .count_pin_b(pin_b),
      .external_interrupt_pin_a(ext_a), .external_interrupt_pin_b(ext_b),
      .vector_ack_a(ack_a), .vector_ack_b(ack_b), .irq_a(irq_a), .irq_b(irq_b));
   count_source count_source_a (.mclk(mclk), .en(en_a), .count_pin(pin_a));
   count_source count_source_b (.mclk(mclk), .en(en_b), .count_pin(pin_b));
   // Random source
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Count value as the counter sees it, 13 or 16 bits
   function logic [15:0] joined(logic [1:0] md, logic [7:0] hi, logic [7:0] lo);
      return md[0] ? {hi, lo} : {3'b000, hi, lo[4:0]};
   endfunction
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single word transfer, waits on hready in both phases
   task bus(input logic [11:0] a, input logic w, input logic [7:0] dt, output logic [7:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, dt};
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata[7:0];
   endtask
   // Preset, run for k ticks of per cycles, stop, then check count and flag
   task run_case(input logic ch, input logic [1:0] md, input logic src, gt, pin,
                 input logic [7:0] cfg, input int per);
      logic [7:0] c, lo, hi, rb, cv;
      logic [11:0] la, ha;
      logic [15:0] s, d, top;
      logic [31:0] t;
      int k, r, n;
      k = 4 + int'(xs() % 6);
      r = int'(xs() % (k - 2));
      t = xs();
      n = (!md[1] && (!gt || pin)) ? k : 0;
      top = md[0] ? 16'hFFFF : 16'h1FFF;
      s = top - 16'(r);
      la = ch ? `OFF_B_LOW : `OFF_A_LOW;
      ha = ch ? `OFF_B_HIGH : `OFF_A_HIGH;
      rb = 8'h01 << (ch ? `CTL_B_RUN : `CTL_A_RUN);
      hi = md[0] ? s[15:8] : s[12:5];
      lo = md[0] ? s[7:0] : {t[7:5], s[4:0]};
      ext_a <= pin;
      ext_b <= pin;
      en_a <= src;
      en_b <= src;
      bus(`OFF_CONTROL, 1, 8'h00, c);
      bus(`OFF_MODE, 1, {4'h0, gt, src, md} << (ch ? 4 : 0), c);
      bus(`OFF_CLKCFG, 1, cfg, c);
      bus(la, 1, lo, c);
      bus(ha, 1, hi, c);
      bus(`OFF_CONTROL, 1, rb, c);
      repeat (per * k) @(posedge mclk);
      bus(`OFF_CONTROL, 0, 8'h00, cv);
      bus(`OFF_CONTROL, 1, cv & ~rb, c);
      bus(la, 0, 8'h00, q);
      bus(ha, 0, 8'h00, c);
      d = (joined(md, c, q) - s) & top;
      chk("delta", 1, d >= n - (n > 0) && d <= n + (n > 0));
      chk("flag", d > r, ch ? irq_b : irq_a);
      chk("ctl run", 1, cv[ch ? `CTL_B_RUN : `CTL_A_RUN]);
      chk("ctl flag", d > r, cv[ch ? `CTL_B_FLAG : `CTL_A_FLAG]);
      if (!md[0]) chk("upper", lo[7:5], q[7:5]);
      ack_a <= !ch;
      ack_b <= ch;
      @(posedge mclk);
      ack_a <= 1'b0;
      ack_b <= 1'b0;
      @(posedge mclk);
      chk("cleared", 0, ch ? irq_b : irq_a);
   endtask
   task tally_and_finish();
      if (mismatches == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #1_000_000;
      mismatches++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 9; i++)
      begin
         bus(12'(4 * i), 0, 8'h00, q);
         if (i != 2 && i != 7) chk("reset", 0, q);
      end
      bus(12'h0FC, 1, 8'hA5, q);
      bus(12'h0FC, 0, 8'h00, q);
      chk("unmapped", 0, q);
      run_case(0, 2'b01, 0, 0, 0, 8'h00, 12);
      run_case(0, 2'b01, 0, 0, 0, 8'h04, 6);
      run_case(0, 2'b01, 0, 0, 0, 8'h05, 12);
      run_case(1, 2'b01, 0, 0, 0, 8'h06, 12);
      run_case(1, 2'b00, 0, 0, 0, 8'h04, 6);
      run_case(0, 2'b00, 0, 0, 0, 8'h00, 12);
      run_case(0, 2'b01, 1, 0, 0, 8'h00, 48);
      run_case(1, 2'b01, 1, 0, 0, 8'h00, 48);
      run_case(0, 2'b01, 0, 1, 0, 8'h00, 12);
      run_case(1, 2'b01, 0, 1, 1, 8'h00, 12);
      run_case(0, 2'b10, 0, 0, 0, 8'h00, 12);
      run_case(1, 2'b11, 0, 0, 0, 8'h00, 12);
      tally_and_finish();
   end
endmodule // dual_timer_counter_core_tb_top
